// ### hw/imc_defines.svh
// register offsets, field layout and reset values of the interrupt mask block
`ifndef IMC_DEFINES_SVH
`define IMC_DEFINES_SVH
`define IMC_ADDR_W          20
`define IMC_OFF_CAUSE_READ  20'h000c0
`define IMC_OFF_MASK_SET    20'h000d0
`define IMC_OFF_MASK_CLEAR  20'h000d8
`define IMC_SRC_W           17
`define IMC_DEF_BITS        17'h1f6df
`define IMC_MASK_RESET      17'h00000
`define IMC_RDATA_RESET     32'h00000000
`define IMC_UPPER_ZERO      15'h0000
`endif

// ### hw/imc_mask_clear.sv
// interrupt mask set/clear registers, cause readback and interrupt gating
`timescale 1ns/1ns
`include "imc_defines.svh"

// ====================================================================
// Behaviour
// [RULE_01] a one written to a defined clear bit clears that mask bit
// [RULE_02] zeros written to the clear register leave mask bits alone
// [RULE_03] interrupt out only while some cause and its mask are both one
// [RULE_04] mask readable via set/read register, cause via cause register
// [RULE_05] software writes ones to reserved clear bits to keep sources masked
// [RULE_06] clear register is write-only at 0xd8, defined bits 16 to 0
// [RULE_07] bits 0,1,2 clear tx written back, tx queue empty, link change
// [RULE_08] bit 3 clears rx sequence error, bit 4 rx descriptor threshold
// [RULE_09] bit 6 clears rx fifo overrun, bit 7 rx timer mask
// [RULE_10] bit 9 clears management access complete mask
// [RULE_11] bit 10 clears rx config ordered sets, bit 12 phy layer mask
// [RULE_12] bits 14:13 clear general purpose, bit 15 tx descriptor low
// [RULE_13] bit 16 clears small rx packet detect mask
// [RULE_14] ones written to set register set mask bits; reading returns mask
// [RULE_15] clear beats set on the same bit; mask zero after reset
module imc_mask_clear (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire imc_pkg::imc_addr_t reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  input  wire imc_pkg::imc_src_t irq_cause,
  output logic                  irq_out,
  output imc_pkg::imc_src_t     irq_mask
);
  import imc_pkg::*;

  // ==================================================================
  // write decode
  imc_wsel_t wsel;
  imc_src_t  mask_r;
  imc_src_t  mask_nxt;
  imc_src_t  set_bits;
  imc_src_t  clr_bits;

  always_comb begin
    wsel = IMC_SEL_NONE;
    if (reg_wr) begin
      case (reg_addr)
        `IMC_OFF_MASK_SET:   wsel = IMC_SEL_SET;
        `IMC_OFF_MASK_CLEAR: wsel = IMC_SEL_CLEAR; // [RULE_06]
        default:             wsel = IMC_SEL_NONE;
      endcase
    end
  end

  // reserved positions are dropped by IMC_DEF_BITS, so their mask flops stay zero and ones written there are harmless
  assign set_bits = (wsel == IMC_SEL_SET) ? (reg_wdata[`IMC_SRC_W-1:0] & `IMC_DEF_BITS)
                                          : `IMC_MASK_RESET; // [RULE_14]
  assign clr_bits = (wsel == IMC_SEL_CLEAR) ? (reg_wdata[`IMC_SRC_W-1:0] & `IMC_DEF_BITS)
                                            : `IMC_MASK_RESET; // [RULE_05] [RULE_06]

  // ==================================================================
  // mask state, one flop per source
  genvar gi;
  generate
    for (gi = 0; gi < `IMC_SRC_W; gi++) begin : g_mask
      // clear wins: a driver disabling a source must never be overridden
      always_comb begin
        if (clr_bits[gi])
          mask_nxt[gi] = 1'b0;          // [RULE_01] [RULE_07] [RULE_08] [RULE_09] [RULE_10] [RULE_11] [RULE_12] [RULE_13] [RULE_15]
        else if (set_bits[gi])
          mask_nxt[gi] = 1'b1;          // [RULE_14]
        else
          mask_nxt[gi] = mask_r[gi];    // [RULE_02]
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mask_r <= `IMC_MASK_RESET;        // [RULE_15]
    end else begin
      mask_r <= mask_nxt;
    end
  end

  assign irq_mask = mask_r;

  // ==================================================================
  // interrupt gating
  always_comb begin
    irq_out = |(irq_cause & mask_r & `IMC_DEF_BITS); // [RULE_03]
  end

  // ==================================================================
  // read path; the clear register is write-only and reads as zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= `IMC_RDATA_RESET;
    end else if (reg_rd) begin
      case (reg_addr)
        `IMC_OFF_MASK_SET:   reg_rdata <= {`IMC_UPPER_ZERO, mask_r};    // [RULE_04]
        `IMC_OFF_CAUSE_READ: reg_rdata <= {`IMC_UPPER_ZERO, irq_cause}; // [RULE_04]
        default:             reg_rdata <= `IMC_RDATA_RESET;             // [RULE_06]
      endcase
    end else begin
      reg_rdata <= `IMC_RDATA_RESET;
    end
  end

  // ==================================================================
  // checks
  property p_clear_bit;
    @(posedge mclk) disable iff (!resetn)
      (reg_wr && reg_addr == `IMC_OFF_MASK_CLEAR && reg_wdata[0]) |=> !mask_r[0];
  endproperty
  a_clear_bit: assert property (p_clear_bit) else $error("mask bit 0 not cleared"); // [RULE_01]

  property p_zero_keeps;
    @(posedge mclk) disable iff (!resetn)
      (reg_wr && reg_addr == `IMC_OFF_MASK_CLEAR && !reg_wdata[16]) |=> mask_r[16] == $past(mask_r[16]);
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero in clear changed mask"); // [RULE_02]

  property p_irq_gate;
    @(posedge mclk) disable iff (!resetn)
      irq_out == ((irq_cause & mask_r) != `IMC_MASK_RESET);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt gating wrong"); // [RULE_03]

  sequence s_mask_read;
    reg_rd && reg_addr == `IMC_OFF_MASK_SET;
  endsequence
  property p_mask_read;
    @(posedge mclk) disable iff (!resetn)
      s_mask_read |=> reg_rdata == {`IMC_UPPER_ZERO, $past(mask_r)};
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask readback wrong"); // [RULE_04]

  property p_clear_reads_zero;
    @(posedge mclk) disable iff (!resetn)
      (reg_rd && reg_addr == `IMC_OFF_MASK_CLEAR) |=> reg_rdata == `IMC_RDATA_RESET;
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear register readable"); // [RULE_06]

  property p_gpi_clear;
    @(posedge mclk) disable iff (!resetn)
      (reg_wr && reg_addr == `IMC_OFF_MASK_CLEAR && reg_wdata[14:13] == 2'h3) |=> mask_r[14:13] == 2'h0;
  endproperty
  a_gpi_clear: assert property (p_gpi_clear) else $error("general purpose masks not cleared"); // [RULE_12]

  sequence s_set_then_idle;
    (reg_wr && reg_addr == `IMC_OFF_MASK_SET && reg_wdata[9]) ##1 !reg_wr;
  endsequence
  property p_set_holds;
    @(posedge mclk) disable iff (!resetn)
      s_set_then_idle |=> mask_r[9];
  endproperty
  a_set_holds: assert property (p_set_holds) else $error("set bit lost"); // [RULE_14]

  property p_reserved_zero;
    @(posedge mclk) disable iff (!resetn)
      (mask_r & ~`IMC_DEF_BITS) == `IMC_MASK_RESET;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved mask bit set"); // [RULE_05]

  property p_cause_read;
    @(posedge mclk) disable iff (!resetn)
      (reg_rd && reg_addr == `IMC_OFF_CAUSE_READ) |=> reg_rdata[16:0] == $past(irq_cause);
  endproperty
  a_cause_read: assert property (p_cause_read) else $error("cause readback wrong"); // [RULE_04]

  // ==================================================================
  // per-field and whole-word checks
  // decode helpers, shared so every field check sees the same strobe
  sequence s_clr_wr;
    reg_wr && reg_addr == `IMC_OFF_MASK_CLEAR;
  endsequence
  sequence s_set_wr;
    reg_wr && reg_addr == `IMC_OFF_MASK_SET;
  endsequence
  sequence s_other_wr;
    reg_wr && reg_addr != `IMC_OFF_MASK_SET && reg_addr != `IMC_OFF_MASK_CLEAR;
  endsequence

  property p_clr_word;
    @(posedge mclk) disable iff (!resetn)
      s_clr_wr |=> mask_r == ($past(mask_r) & ~$past(reg_wdata[`IMC_SRC_W-1:0]));
  endproperty
  a_clr_word: assert property (p_clr_word) else $error("clear word result wrong"); // [RULE_01]

  property p_set_word;
    @(posedge mclk) disable iff (!resetn)
      s_set_wr |=> mask_r == ($past(mask_r) | ($past(reg_wdata[`IMC_SRC_W-1:0]) & `IMC_DEF_BITS));
  endproperty
  a_set_word: assert property (p_set_word) else $error("set word result wrong"); // [RULE_14]

  property p_idle_stable;
    @(posedge mclk) disable iff (!resetn)
      !reg_wr |=> $stable(mask_r);
  endproperty
  a_idle_stable: assert property (p_idle_stable) else $error("mask moved without a write"); // [RULE_02]

  property p_other_wr;
    @(posedge mclk) disable iff (!resetn)
      s_other_wr |=> $stable(mask_r);
  endproperty
  a_other_wr: assert property (p_other_wr) else $error("unmapped write moved mask"); // [RULE_06]

  property p_bit0_keep;
    @(posedge mclk) disable iff (!resetn)
      s_clr_wr ##0 !reg_wdata[0] |=> mask_r[0] == $past(mask_r[0]);
  endproperty
  a_bit0_keep: assert property (p_bit0_keep) else $error("zero in clear changed bit 0"); // [RULE_02]

  property p_tx_queue_empty;
    @(posedge mclk) disable iff (!resetn)
      s_clr_wr ##0 reg_wdata[1] |=> !mask_r[1];
  endproperty
  a_tx_queue_empty: assert property (p_tx_queue_empty) else $error("tx queue empty mask not cleared"); // [RULE_07]

  property p_lsc;
    @(posedge mclk) disable iff (!resetn)
      s_clr_wr ##0 reg_wdata[2] |=> !mask_r[2];
  endproperty
  a_lsc: assert property (p_lsc) else $error("link change mask not cleared"); // [RULE_07]

  property p_rx_sequence_error;
    @(posedge mclk) disable iff (!resetn)
      s_clr_wr ##0 reg_wdata[3] |=> !mask_r[3];
  endproperty
  a_rx_sequence_error: assert property (p_rx_sequence_error) else $error("rx sequence error mask not cleared"); // [RULE_08]

  property p_rxdmt;
    @(posedge mclk) disable iff (!resetn)
      s_clr_wr ##0 reg_wdata[4] |=> !mask_r[4];
  endproperty
  a_rxdmt: assert property (p_rxdmt) else $error("rx threshold mask not cleared"); // [RULE_08]

  property p_rxo;
    @(posedge mclk) disable iff (!resetn)
      s_clr_wr ##0 reg_wdata[6] |=> !mask_r[6];
  endproperty
  a_rxo: assert property (p_rxo) else $error("rx overrun mask not cleared"); // [RULE_09]

  property p_rxt;
    @(posedge mclk) disable iff (!resetn)
      s_clr_wr ##0 reg_wdata[7] |=> !mask_r[7];
  endproperty
  a_rxt: assert property (p_rxt) else $error("rx timer mask not cleared"); // [RULE_09]

  property p_mgmt_access_complete;
    @(posedge mclk) disable iff (!resetn)
      s_clr_wr ##0 reg_wdata[9] |=> !mask_r[9];
  endproperty
  a_mgmt_access_complete: assert property (p_mgmt_access_complete) else $error("management access mask not cleared"); // [RULE_10]

  property p_rx_config_ordered_sets;
    @(posedge mclk) disable iff (!resetn)
      s_clr_wr ##0 reg_wdata[10] |=> !mask_r[10];
  endproperty
  a_rx_config_ordered_sets: assert property (p_rx_config_ordered_sets) else $error("ordered sets mask not cleared"); // [RULE_11]

  property p_phy;
    @(posedge mclk) disable iff (!resetn)
      s_clr_wr ##0 reg_wdata[12] |=> !mask_r[12];
  endproperty
  a_phy: assert property (p_phy) else $error("phy layer mask not cleared"); // [RULE_11]

  property p_txdlow;
    @(posedge mclk) disable iff (!resetn)
      s_clr_wr ##0 reg_wdata[15] |=> !mask_r[15];
  endproperty
  a_txdlow: assert property (p_txdlow) else $error("tx descriptor low mask not cleared"); // [RULE_12]

  property p_small_rx_packet_detect;
    @(posedge mclk) disable iff (!resetn)
      s_clr_wr ##0 reg_wdata[16] |=> !mask_r[16];
  endproperty
  a_small_rx_packet_detect: assert property (p_small_rx_packet_detect) else $error("small packet mask not cleared"); // [RULE_13]

  // reserved positions are dropped by IMC_DEF_BITS; a set there must not leak into the mask
  property p_rsvd_set;
    @(posedge mclk) disable iff (!resetn)
      s_set_wr ##0 reg_wdata[5] |=> !mask_r[5];
  endproperty
  a_rsvd_set: assert property (p_rsvd_set) else $error("reserved bit took a set"); // [RULE_06]

  property p_rd_idle;
    @(posedge mclk) disable iff (!resetn)
      !reg_rd |=> reg_rdata == `IMC_RDATA_RESET;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle"); // [RULE_04]

  property p_rd_upper;
    @(posedge mclk) disable iff (!resetn)
      reg_rd |=> reg_rdata[31:`IMC_SRC_W] == `IMC_UPPER_ZERO;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("reserved read bits not zero"); // [RULE_04]

  property p_rd_unmapped;
    @(posedge mclk) disable iff (!resetn)
      (reg_rd && reg_addr != `IMC_OFF_MASK_SET && reg_addr != `IMC_OFF_CAUSE_READ) |=> reg_rdata == `IMC_RDATA_RESET;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero"); // [RULE_06]

  property p_irq_off;
    @(posedge mclk) disable iff (!resetn)
      (irq_mask == `IMC_MASK_RESET) |-> !irq_out;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt with all masks off"); // [RULE_03]

endmodule // imc_mask_clear

// ### hw/imc_pkg.sv
// types shared by the interrupt mask block
package imc_pkg;
  `include "imc_defines.svh"
  typedef logic [`IMC_SRC_W-1:0] imc_src_t;
  typedef logic [`IMC_ADDR_W-1:0] imc_addr_t;
  typedef enum logic [2:0] {
    IMC_SEL_NONE  = 3'h1,
    IMC_SEL_SET   = 3'h2,
    IMC_SEL_CLEAR = 3'h4
  } imc_wsel_t;
endpackage

// ### tb/imc_cause_src.sv
// cause source model standing in for the neighbouring cause register
`timescale 1ns/1ns
`include "imc_defines.svh"
// ====================================================================
// cause source
module imc_cause_src (
  input  wire logic         mclk,
  output imc_pkg::imc_src_t cause
);
  import imc_pkg::*;
  integer seed = 32'h2aa9;
  initial cause = '0;
  // moves right after each rising edge, so the next rising edge samples a settled value
  always @(posedge mclk) cause <= imc_src_t'($random(seed)) & `IMC_DEF_BITS;
endmodule // imc_cause_src

// ### tb/interrupt_mask_clear_tb.sv
// self-checking bench of the interrupt mask block
`timescale 1ns/1ns
`include "imc_defines.svh"
// ====================================================================
// bench
module interrupt_mask_clear_tb;
  import imc_pkg::*;
  logic        mclk = 1'b0;
  logic        resetn, reg_wr, reg_rd, irq_out;
  imc_addr_t   reg_addr;
  logic [31:0] reg_wdata, reg_rdata, wd;
  imc_src_t    irq_cause, irq_mask, m;
  integer      seed = 32'h2aa9;
  integer      n_fail = 0;
  integer      checks_done = 0;
  integer      i;
  always #5 mclk = ~mclk;
  imc_mask_clear dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_cause(irq_cause),
    .irq_out(irq_out), .irq_mask(irq_mask));
  imc_cause_src cause_src (.mclk(mclk), .cause(irq_cause));
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wr(imc_addr_t a, logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
    if (a === `IMC_OFF_MASK_SET) m = m | (d[16:0] & `IMC_DEF_BITS);
    if (a === `IMC_OFF_MASK_CLEAR) m = m & ~d[16:0];
    chk("mask", irq_mask, m);
  endtask
  task rd(imc_addr_t a);
    logic [31:0] e;
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    // cause holds from here until the edge that takes the read
    #1 e = (a === `IMC_OFF_MASK_SET) ? {15'h0000, m} : (a === `IMC_OFF_CAUSE_READ) ? {15'h0000, irq_cause} : 32'h0;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
    @(posedge mclk);
    #1 chk("rdata idle", reg_rdata, 32'h0);
  endtask
  // cause changes on the rising edge, so two ns after that edge all is settled
  always @(posedge mclk) begin
    #2;
    if (resetn) chk("irq", irq_out, {31'h0, |(irq_cause & m)});
  end
  initial begin
    #1000000;
    n_fail++;
    complete_run;
  end
  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    m = '0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    #1 chk("reset mask", irq_mask, 17'h0);
    rd(`IMC_OFF_MASK_SET);
    for (i = 0; i < 17; i++) begin
      if (`IMC_DEF_BITS >> i & 1) begin
        wr(`IMC_OFF_MASK_SET, 32'h1ffff);
        wr(`IMC_OFF_MASK_CLEAR, 32'h1 << i);
        chk("bit", irq_mask[i], 32'h0);
      end
    end
    for (i = 0; i < 200; i++) begin
      wd = $random(seed);
      wr(`IMC_OFF_MASK_SET, wd);
      rd(`IMC_OFF_MASK_SET);
      rd(`IMC_OFF_CAUSE_READ);
      wr(`IMC_OFF_MASK_CLEAR, $random(seed) | 32'hfffe0920);
      rd(`IMC_OFF_MASK_CLEAR);
      wr(20'h00100, wd);
    end
    // second reset at the end of the run must wipe the mask again
    wr(`IMC_OFF_MASK_SET, 32'h1ffff);
    resetn <= 1'b0;
    m = '0;
    @(posedge mclk);
    resetn <= 1'b1;
    #1 chk("reset mask", irq_mask, 17'h0);
    complete_run;
  end
endmodule // interrupt_mask_clear_tb
